// [ranging_cfg.svh]
/*
  Constants of the ranging command port: register offsets, reset
  values, opcodes, field positions and timing counts.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef RANGING_CFG_SVH
`define RANGING_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PARAM_LOW     8'h08
`define OFS_PARAM_HIGH    8'h0f
`define OFS_PARAM_BYTE_1  8'h0e
`define OFS_PARAM_BYTE_0  8'h0f
`define OFS_OPCODE        8'h10
`define OFS_TID           8'h03
`define OFS_IRQ_STATUS    8'he1
`define OFS_IRQ_ENABLE    8'he2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PARAM         8'h00
`define RST_OPCODE        8'h00
`define RST_TID           8'h00

// ----------------------------------------------------------------
// opcodes and fields
// ----------------------------------------------------------------
`define OP_MEASURE_CAL    8'h02
`define OP_MEASURE        8'h03
`define BIT_FACTORY_CAL   0
`define BIT_ALG_STATE     1
`define BIT_DETECT_IRQ    0
`define IDX_CAL_MASK      7

// ----------------------------------------------------------------
// timing: one iteration unit is 1 k raw iterations
// ----------------------------------------------------------------
`define ITER_UNIT         1000
`define STEP_CYCLES       16

`endif

// [ranging_pkg.sv]
/*
  Types shared by the ranging command port and its sequencer.
  Assumes ranging_cfg.svh is on the include path.
*/
package ranging_pkg;
  `include "ranging_cfg.svh"

  typedef enum logic [1:0] {seq_idle, seq_run, seq_finish} seq_state_type;
  typedef logic [7:0] byte_type;
endpackage

// [meas_if.sv]
/*
  Carrier between the command decoder and the measurement sequencer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface meas_if;
  logic        start;
  logic [15:0] iterations;
  logic        done;
  logic        running;

  modport decoder   (output start, output iterations,
                     input done, input running);
  modport sequencer (input start, input iterations,
                     output done, output running);
endinterface

// [measure_sequencer.sv]
/*
  Measurement sequencer: runs one measurement whose length follows
  the iteration count, then pulses done for one cycle.
  Assumes start is only raised while running is low.
*/
`timescale 1ns/100ps
`include "ranging_cfg.svh"
module measure_sequencer
#(
  parameter int STEP_CYCLES = `STEP_CYCLES
)
(
  input wire logic mclk,
  input wire logic arst_n,
  meas_if.sequencer       mio
);
  import ranging_pkg::*;

  seq_state_type state;
  logic [15:0]   steps_left;
  logic [15:0]   step_cnt;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // a zero count still takes one step so done always follows start
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      state      <= seq_idle;
      steps_left <= 16'h0000;
      step_cnt   <= 16'h0000;
      mio.done   <= 1'b0;
    end
    else
    begin
      mio.done <= 1'b0;
      case (state)
        seq_idle:
          if (mio.start)
          begin
            state      <= seq_run;
            steps_left <= (mio.iterations == 16'h0000) ? 16'h0001
                                                       : mio.iterations;
            step_cnt   <= 16'(STEP_CYCLES - 1);
          end
        seq_run:
          if (step_cnt != 16'h0000)
            step_cnt <= step_cnt - 16'h0001;
          else if (steps_left == 16'h0001)
            state <= seq_finish;
          else
          begin
            steps_left <= steps_left - 16'h0001;
            step_cnt   <= 16'(STEP_CYCLES - 1);
          end
        seq_finish:
        begin
          mio.done <= 1'b1;
          state    <= seq_idle;
        end
        default:
          state <= seq_idle;
      endcase
    end

  assign mio.running = (state != seq_idle);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  done_after_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
    mio.done |-> $past(state) == seq_finish)
    else $error("done without finishing a run");
endmodule // measure_sequencer

// [ranging_command_port.sv]
/*
  Ranging command port: parameter byte registers, opcode register,
  measurement start, detection interrupt and transaction id.
  Assumes a serial register front end that presents one-cycle read
  and write strobes with an 8-bit address, synchronous to mclk.
*/
`timescale 1ns/100ps
`include "ranging_cfg.svh"
module ranging_command_port
#(
  parameter int STEP_CYCLES = `STEP_CYCLES
)
(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic [7:0]           reg_addr,
  input  wire ranging_pkg::byte_type reg_wdata,
  input  wire logic                 reg_we,
  input  wire logic                 reg_re,
  output ranging_pkg::byte_type     reg_rdata,
  output logic                      int_n,
  output logic                      busy,
  output logic                      with_cal,
  output logic                      factory_cal_present,
  output logic                      algorithm_state_present,
  output logic [15:0]               iterations,
  output logic [39:0]               meas_config
);
  import ranging_pkg::*;

  byte_type param [0:7];
  byte_type opcode;
  byte_type tid;
  logic     detect_irq_flag;
  logic     detect_irq_enable;
  logic     opcode_we;
  logic     start;
  logic     next_flag;
  meas_if   mio ();

  function automatic logic [2:0] param_index(input logic [7:0] addr);
    param_index = 3'(`OFS_PARAM_HIGH - addr);
  endfunction

  function automatic logic is_param(input logic [7:0] addr);
    is_param = (addr >= `OFS_PARAM_LOW) && (addr <= `OFS_PARAM_HIGH);
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      for (int i = 0; i < 8; i++)
        param[i] <= `RST_PARAM;
    else if (reg_we && is_param(reg_addr))
      param[param_index(reg_addr)] <= reg_wdata;

  assign opcode_we = reg_we && (reg_addr == `OFS_OPCODE);

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      opcode <= `RST_OPCODE;
    else if (opcode_we)
      opcode <= reg_wdata;

  // an opcode written while busy is stored but starts nothing
  assign start = opcode_we && !busy &&
                 ((reg_wdata == `OP_MEASURE_CAL) ||
                  (reg_wdata == `OP_MEASURE));

  // ----------------------------------------------------------------
  // parameter capture at the opcode write
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      with_cal                <= 1'b0;
      factory_cal_present     <= 1'b0;
      algorithm_state_present <= 1'b0;
      iterations              <= 16'h0000;
      meas_config             <= 40'h00_0000_0000;
    end
    else if (start)
    begin
      with_cal    <= (reg_wdata == `OP_MEASURE_CAL);
      iterations  <= {param[0], param[1]};
      meas_config <= {param[6], param[5], param[4],
                      param[3], param[2]};
      if (reg_wdata == `OP_MEASURE_CAL)
      begin
        // state data implies calibration even if bit 0 was missed
        factory_cal_present <=
          param[`IDX_CAL_MASK][`BIT_FACTORY_CAL] |
          param[`IDX_CAL_MASK][`BIT_ALG_STATE];
        algorithm_state_present <=
          param[`IDX_CAL_MASK][`BIT_ALG_STATE];
      end
      else
      begin
        factory_cal_present     <= 1'b0;
        algorithm_state_present <= 1'b0;
      end
    end

  // ----------------------------------------------------------------
  // busy and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      busy <= 1'b0;
    else if (start)
      busy <= 1'b1;
    else if (mio.done)
      busy <= 1'b0;

  assign mio.start      = start;
  assign mio.iterations = {param[0], param[1]};

  measure_sequencer #(.STEP_CYCLES(STEP_CYCLES)) sequencer_u
  (
    .mclk   (mclk),
    .arst_n (arst_n),
    .mio    (mio.sequencer)
  );

  // ----------------------------------------------------------------
  // completion: flag, interrupt pin, transaction id
  // ----------------------------------------------------------------
  // completion beats a same-cycle write-one-to-clear
  always_comb
  begin
    next_flag = detect_irq_flag;
    if (reg_we && (reg_addr == `OFS_IRQ_STATUS) &&
        reg_wdata[`BIT_DETECT_IRQ])
      next_flag = 1'b0;
    if (mio.done)
      next_flag = 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      detect_irq_flag <= 1'b0;
      int_n           <= 1'b1;
    end
    else
    begin
      detect_irq_flag <= next_flag;
      int_n           <= !(next_flag && detect_irq_enable);
    end

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      detect_irq_enable <= 1'b0;
    else if (reg_we && (reg_addr == `OFS_IRQ_ENABLE))
      detect_irq_enable <= reg_wdata[`BIT_DETECT_IRQ];

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      tid <= `RST_TID;
    else if (mio.done)
      tid <= tid + 8'h01;

  // ----------------------------------------------------------------
  // register reads; parameter bytes are write-only and read zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_re)
      case (reg_addr)
        `OFS_OPCODE:     reg_rdata <= opcode;
        `OFS_TID:        reg_rdata <= tid;
        `OFS_IRQ_STATUS: reg_rdata <= {7'h00, detect_irq_flag};
        `OFS_IRQ_ENABLE: reg_rdata <= {7'h00, detect_irq_enable};
        default:         reg_rdata <= 8'h00;
      endcase

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  param_readzero_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_re && is_param(reg_addr) |=> reg_rdata == 8'h00)
    else $error("parameter byte read not zero");
  opcode_readback_a: assert property (@(posedge mclk) disable iff (!arst_n)
    opcode_we ##1 !opcode_we ##1
    (reg_re && reg_addr == `OFS_OPCODE && !opcode_we)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("opcode readback mismatch");
  cal_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start && reg_wdata == `OP_MEASURE_CAL |=> with_cal && busy)
    else $error("calibrated measurement not started");
  factory_cal_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start && reg_wdata == `OP_MEASURE_CAL && param[7][0]
    |=> factory_cal_present)
    else $error("factory calibration not flagged");
  alg_state_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start && reg_wdata == `OP_MEASURE_CAL && param[7][1]
    |=> factory_cal_present && algorithm_state_present)
    else $error("algorithm state not flagged");
  shared_config_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start |=> meas_config[39:32] == $past(param[6]) &&
              meas_config[7:0] == $past(param[2]))
    else $error("config bytes not captured");
  plain_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start && reg_wdata == `OP_MEASURE
    |=> !with_cal && !factory_cal_present && !algorithm_state_present)
    else $error("plain measurement uses calibration");
  completion_irq_a: assert property (@(posedge mclk) disable iff (!arst_n)
    mio.done && detect_irq_enable |=> detect_irq_flag && !int_n &&
                                      tid == $past(tid) + 8'h01)
    else $error("completion not reported");
  iter_order_a: assert property (@(posedge mclk) disable iff (!arst_n)
    start |=> iterations == {$past(param[0]), $past(param[1])})
    else $error("iteration bytes swapped");
  capture_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    busy && !start ##1 busy |-> $stable(iterations) && $stable(meas_config))
    else $error("captured parameters changed mid run");
  busy_tracks_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
    mio.running |-> busy)
    else $error("sequencer running while port idle");
endmodule // ranging_command_port

// [host_model.sv]
/*
  Host model: a processor on the register port of the ranging block.
  Assumes one-cycle strobes, taken at the rising edge of mclk.
*/
`timescale 1ns/100ps
module host_model
(
  input  wire logic                  mclk,
  output logic [7:0]                 reg_addr,
  output ranging_pkg::byte_type      reg_wdata,
  output logic                       reg_we,
  output logic                       reg_re,
  input  wire ranging_pkg::byte_type reg_rdata
);
  import ranging_pkg::*;
  `include "ranging_cfg.svh"

  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines flip so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] a, input byte_type d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output byte_type d);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // parameter bytes always go in before the opcode that uses them
  task automatic send_cmd(input byte_type op, input byte_type b[8]);
    for (int i = 7; i >= 0; i--)
      wr(8'h0f - 8'(i), b[i]);
    wr(`OFS_OPCODE, op);
  endtask
endmodule // host_model

// [testbench.sv]
/*
  Self-checking bench of the ranging command port.
  Assumes the host model drives the register port.
*/
`timescale 1ns/100ps
module testbench;
  import ranging_pkg::*;
  `include "ranging_cfg.svh"

  logic        mclk, arst_n, reg_we, reg_re, int_n, busy, with_cal;
  logic        fcal, algst;
  logic [7:0]  reg_addr;
  byte_type    reg_wdata, reg_rdata, rv, op;
  byte_type    b[8];
  logic [15:0] iterations;
  logic [39:0] meas_config;
  logic        en;
  int          num_errors, tests_run;

  ranging_command_port #(.STEP_CYCLES(2)) i_ranging_command_port
  (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .int_n(int_n), .busy(busy),
    .with_cal(with_cal), .factory_cal_present(fcal),
    .algorithm_state_present(algst), .iterations(iterations),
    .meas_config(meas_config)
  );

  host_model i_host_model
  (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd_check(input logic [7:0] a, input byte_type exp);
    i_host_model.rd(a, rv);
    check(rv, exp);
  endtask

  // bounded wait: a hung measurement ends the run
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0)
    begin
      @(posedge mclk);
      #1 n++;
      if (n > 2000)
      begin
        num_errors++;
        wrap_up();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    void'($urandom(29));
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    #1 check(busy, 1'b0);
    check(int_n, 1'b1);
    rd_check(`OFS_OPCODE, `RST_OPCODE);
    rd_check(`OFS_PARAM_BYTE_1, 8'h00);
    rd_check(`OFS_PARAM_BYTE_0, 8'h00);
    rd_check(`OFS_TID, `RST_TID);
    rd_check(8'h55, 8'h00);
    $display("test reset done");
    for (int t = 0; t < 12; t++)
    begin
      foreach (b[i])
        b[i] = 8'($urandom);
      b[0] = 8'($urandom % 2);
      b[1] = 8'(3 + $urandom % 12);
      b[6][0] = 1'b1;
      b[7] = 8'($urandom % 4);
      if (b[7][1])
        b[7][0] = 1'b1;
      op = t[0] ? `OP_MEASURE : `OP_MEASURE_CAL;
      en = t[1];
      i_host_model.wr(`OFS_IRQ_ENABLE, {7'h00, en});
      i_host_model.send_cmd(op, b);
      #1 check(busy, 1'b1);
      check(with_cal, op == `OP_MEASURE_CAL);
      check(fcal, !t[0] && (b[7][0] || b[7][1]));
      check(algst, !t[0] && b[7][1]);
      check(iterations, {b[0], b[1]});
      check(meas_config, {b[6], b[5], b[4], b[3], b[2]});
      i_host_model.wr(`OFS_PARAM_BYTE_1, ~b[1]);
      i_host_model.wr(`OFS_OPCODE, `OP_MEASURE);
      #1 check(iterations, {b[0], b[1]});
      check(with_cal, op == `OP_MEASURE_CAL);
      wait_idle();
      check(int_n, !en);
      rd_check(`OFS_TID, 8'(t + 1));
      rd_check(`OFS_IRQ_STATUS, 8'h01);
      i_host_model.wr(`OFS_IRQ_STATUS, 8'h01);
      #1 check(int_n, 1'b1);
      rd_check(`OFS_OPCODE, `OP_MEASURE);
      $display("test %0d done", t);
    end
    // reset in mid-measurement must drop busy, with_cal, the captured iterations and the transaction id
    i_host_model.send_cmd(`OP_MEASURE_CAL, b);
    #1 check(busy, 1'b1);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1 check(busy, 1'b0);
    check(int_n, 1'b1);
    check(with_cal, 1'b0);
    check(iterations, 16'h0000);
    rd_check(`OFS_TID, `RST_TID);
    rd_check(`OFS_OPCODE, `RST_OPCODE);
    // an unknown opcode is stored and starts nothing
    i_host_model.wr(`OFS_OPCODE, 8'h5a);
    #1 check(busy, 1'b0);
    rd_check(`OFS_OPCODE, 8'h5a);
    $display("test mid run reset done");
    wrap_up();
  end
endmodule // testbench
